/* rtl/clk_route_cfg.sv */
// Module: clock pin, stage enable and output routing configuration bank with AXI4-Lite slave
//
// Contract
// - With differential select set the clock comes from the primary pin pair, else from the shared pin (first-pin input enable set) or the data clock input.
// - With first-pin input enable set the shared pin is a clock input, else it drives the data clock out.
// - With the hold bit set the single-ended clock path is held at one.
// - The differential clock delay field adds 0 to 3 delay steps.
// - The single-ended clock delay field applies the same steps independently.
// - The test-word enable feeds the written 16-bit word to both channels.
// - The output delay field holds both outputs back 0 to 3 cycles.
// - Copy A to B alone puts A on both outputs; both route bits swap the outputs.
// - Copy B to A alone puts B on both outputs; both clear routes normally.
// - The stage register resets to 0xe1.
// - The delay register resets to zero and its low four bits have no function.
// - The routing register resets to zero and its bit two is unused.
// - Each port reversal flag mirrors the bit order of that port's word.
`timescale 1ns/1ps
`default_nettype none
module clk_route_cfg (
	// Clock, reset, enable
	input  wire logic                        clk_sys_in,
	input  wire logic                        reset_n_in,
	input  wire logic                        clk_en_in,
	// AXI4-Lite slave
	input  wire logic [7:0]                  s_axi_awaddr_in,
	input  wire logic                        s_axi_awvalid_in,
	output logic                             s_axi_awready_out,
	input  wire logic [31:0]                 s_axi_wdata_in,
	input  wire logic [3:0]                  s_axi_wstrb_in,
	input  wire logic                        s_axi_wvalid_in,
	output logic                             s_axi_wready_out,
	output logic [1:0]                       s_axi_bresp_out,
	output logic                             s_axi_bvalid_out,
	input  wire logic                        s_axi_bready_in,
	input  wire logic [7:0]                  s_axi_araddr_in,
	input  wire logic                        s_axi_arvalid_in,
	output logic                             s_axi_arready_out,
	output logic [31:0]                      s_axi_rdata_out,
	output logic [1:0]                       s_axi_rresp_out,
	output logic                             s_axi_rvalid_out,
	input  wire logic                        s_axi_rready_in,
	// Clock pins and lock
	input  wire logic                        primary_clock_pin_in,
	input  wire logic                        complementary_clock_pin_in,
	input  wire logic                        shared_clock_pin_in,
	input  wire logic                        pll_lock_in,
	input  wire logic                        data_clock_in,
	output clk_route_pkg::pin_drive_t        shared_clock_pin_out,
	output clk_route_pkg::pin_drive_t        complementary_clock_pin_out,
	output logic                             diff_clock_out,
	output logic                             single_ended_clock_out,
	// Stage enables
	output clk_route_pkg::stage_cfg_t        stage_cfg_out,
	// Sample path
	input  wire clk_route_pkg::sample_pair_t port_samples_in,
	input  wire clk_route_pkg::sample_pair_t stage_samples_in,
	output clk_route_pkg::sample_pair_t      port_samples_out,
	output clk_route_pkg::sample_pair_t      converter_samples_out
);
	import clk_route_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] pin_meta_q;
	logic [4:0] pin_sync_q;
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_meta_q <= 5'h00;
			pin_sync_q <= 5'h00;
		end else if (clk_en_in) begin
			pin_meta_q <= {primary_clock_pin_in, complementary_clock_pin_in,
				shared_clock_pin_in, pll_lock_in, data_clock_in};
			pin_sync_q <= pin_meta_q;
		end
	end
	logic prim_s, compl_s, shared_s, lock_s, dclk_s;
	assign {prim_s, compl_s, shared_s, lock_s, dclk_s} = pin_sync_q;

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]  stage_q;
	logic [3:0]  tree_dly_q;
	logic [7:0]  routing_q;
	sample_t     test_word_q;

	// ****************************************
	// AXI4-Lite write
	// ****************************************
	logic [7:0] aw_addr_q;
	logic       aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic       w_have_q;
	logic       do_write;
	logic       aw_have_d, w_have_d, bvalid_d, rvalid_d;
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid_out;
	// Readies come from flops fed by the next handshake state, same timing as a decoded ready
	always_comb begin
		aw_have_d = (s_axi_awvalid_in && s_axi_awready_out) || (aw_have_q && !do_write);
		w_have_d  = (s_axi_wvalid_in && s_axi_wready_out) || (w_have_q && !do_write);
		bvalid_d  = do_write || (s_axi_bvalid_out && !s_axi_bready_in);
		rvalid_d  = (s_axi_arvalid_in && s_axi_arready_out)
			|| (s_axi_rvalid_out && !s_axi_rready_in);
	end
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_arready_out <= 1'b1;
		end else if (clk_en_in) begin
			s_axi_awready_out <= !aw_have_d && !bvalid_d;
			s_axi_wready_out  <= !w_have_d && !bvalid_d;
			s_axi_arready_out <= !rvalid_d;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (clk_en_in) begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_in;
			end else if (do_write)
				aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (clk_en_in) begin
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end else if (do_write)
				w_have_q <= 1'b0;
		end
	end

	logic wr_hit;
	always_comb begin
		unique case (aw_addr_q & 8'hfc)
			addr_stage_enables, addr_tree_delay, addr_routing, addr_test_word: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage_q     <= rst_stage_enables;
			tree_dly_q  <= rst_tree_delay[7:4];
			routing_q   <= rst_routing;
			test_word_q <= rst_test_word;
		end else if (clk_en_in && do_write) begin
			if (w_strb_q[0]) begin
				unique case (aw_addr_q & 8'hfc)
					addr_stage_enables: stage_q <= w_data_q[7:0];
					// Low nibble has no storage
					addr_tree_delay:    tree_dly_q <= w_data_q[7:4];
					// Bit two is not stored
					addr_routing:       routing_q <= w_data_q[7:0] & 8'hfb;
					addr_test_word:     test_word_q[7:0] <= w_data_q[7:0];
					default: ;
				endcase
			end
			if (w_strb_q[1] && (aw_addr_q & 8'hfc) == addr_test_word)
				test_word_q[15:8] <= w_data_q[15:8];
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= resp_okay;
		end else if (clk_en_in) begin
			if (do_write) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_hit ? resp_okay : resp_slverr;
			end else if (s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read
	// ****************************************
	logic [31:0] rd_word;
	logic        rd_hit;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr_in & 8'hfc)
			addr_stage_enables: rd_word = {24'h000000, stage_q};
			addr_tree_delay:    rd_word = {24'h000000, tree_dly_q, 4'h0};
			addr_routing:       rd_word = {24'h000000, routing_q};
			addr_test_word:     rd_word = {16'h0000, test_word_q};
			addr_port_data:     rd_word = port_samples_out;
			addr_status:        rd_word = {27'h0000000, prim_s, compl_s, shared_s, lock_s, dclk_s};
			default:            rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h0000_0000;
			s_axi_rresp_out  <= resp_okay;
		end else if (clk_en_in) begin
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out  <= rd_word;
				s_axi_rresp_out  <= rd_hit ? resp_okay : resp_slverr;
			end else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// ****************************************
	// Clock pin use and delay trees
	// ****************************************
	logic diff_src, se_src, diff_dly, se_dly;
	// Differential: pair must disagree; single ended: shared pin if first-pin input enable is set, else data clock input
	assign diff_src = prim_s & ~compl_s;
	// Hold forces one so the unused path stays quiet
	assign se_src = stage_q[bit_se_hold] ? 1'b1 :
		(stage_q[bit_first_pin_in] ? shared_s : dclk_s);

	tap_delay u_diff_dly (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.enable_in  (clk_en_in),
		.sig_in     (diff_src),
		.sel_in     (tree_dly_q[pos_diff_dly-4 +: 2]),
		.sig_out    (diff_dly)
	);
	tap_delay u_se_dly (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.enable_in  (clk_en_in),
		.sig_in     (se_src),
		.sel_in     (tree_dly_q[pos_se_dly-4 +: 2]),
		.sig_out    (se_dly)
	);

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			diff_clock_out              <= 1'b0;
			single_ended_clock_out      <= 1'b0;
			shared_clock_pin_out        <= '0;
			complementary_clock_pin_out <= '0;
			stage_cfg_out               <= stage_cfg_t'(rst_stage_enables);
		end else if (clk_en_in) begin
			diff_clock_out         <= stage_q[bit_diff_clock] ? diff_dly : 1'b0;
			single_ended_clock_out <= stage_q[bit_diff_clock] ? 1'b0 : se_dly;
			shared_clock_pin_out <= '{out_en: ~stage_q[bit_first_pin_in],
				out_val: dclk_s};
			complementary_clock_pin_out <= '{out_en: ~stage_q[bit_compl_pin_in],
				out_val: lock_s};
			stage_cfg_out <= stage_cfg_t'(stage_q);
		end
	end

	// ****************************************
	// Sample path
	// ****************************************
	function automatic sample_t mirror(input sample_t v);
		sample_t r;
		r = '0;
		for (int i = 0; i < sample_width; i++)
			r[i] = v[sample_width-1-i];
		return r;
	endfunction

	sample_pair_t routed, delay_q [max_out_delay:1];
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			port_samples_out <= '0;
		else if (clk_en_in) begin
			port_samples_out.chan_one <= routing_q[bit_reverse_a] ?
				mirror(port_samples_in.chan_one) : port_samples_in.chan_one;
			port_samples_out.chan_two <= routing_q[bit_reverse_b] ?
				mirror(port_samples_in.chan_two) : port_samples_in.chan_two;
		end
	end

	always_comb begin
		routed = stage_samples_in;
		unique case ({routing_q[bit_copy_a_to_b], routing_q[bit_copy_b_to_a]})
			2'b00: routed = stage_samples_in;
			2'b01: routed = '{chan_one: stage_samples_in.chan_two,
				chan_two: stage_samples_in.chan_two};
			2'b10: routed = '{chan_one: stage_samples_in.chan_one,
				chan_two: stage_samples_in.chan_one};
			2'b11: routed = '{chan_one: stage_samples_in.chan_two,
				chan_two: stage_samples_in.chan_one};
		endcase
		if (routing_q[bit_test_word_ena])
			routed = '{chan_one: test_word_q, chan_two: test_word_q};
	end

	genvar g;
	generate
		for (g = 1; g <= max_out_delay; g++) begin : g_out_dly
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in)
					delay_q[g] <= '0;
				else if (clk_en_in)
					delay_q[g] <= (g == 1) ? routed : delay_q[(g == 1) ? 1 : g-1];
			end
		end
	endgenerate

	// Output register itself is the zero-delay stage
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			converter_samples_out <= '0;
		else if (clk_en_in) begin
			if (routing_q[pos_out_dly +: 2] == 2'h0)
				converter_samples_out <= routed;
			else
				converter_samples_out <= delay_q[routing_q[pos_out_dly +: 2]];
		end
	end
endmodule // clk_route_cfg
`default_nettype wire

/* rtl/clk_route_pkg.sv */
// Package: register map, field positions, reset values and types of the clock and route bank
package clk_route_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] idx_stage_enables = 8'h02;
	localparam logic [7:0] idx_tree_delay    = 8'h03;
	localparam logic [7:0] idx_routing       = 8'h04;
	localparam logic [7:0] idx_test_word     = 8'h05;
	localparam logic [7:0] idx_port_data     = 8'h06;
	localparam logic [7:0] idx_status        = 8'h07;
	localparam logic [7:0] addr_stage_enables = 8'h08;
	localparam logic [7:0] addr_tree_delay    = 8'h0c;
	localparam logic [7:0] addr_routing       = 8'h10;
	localparam logic [7:0] addr_test_word     = 8'h14;
	localparam logic [7:0] addr_port_data     = 8'h18;
	localparam logic [7:0] addr_status        = 8'h1c;
	localparam logic [7:0] rst_stage_enables  = 8'he1;
	localparam logic [7:0] rst_tree_delay     = 8'h00;
	localparam logic [7:0] rst_routing        = 8'h00;
	localparam logic [15:0] rst_test_word     = 16'h0000;
	localparam logic [1:0] resp_okay          = 2'h0;
	localparam logic [1:0] resp_slverr        = 2'h2;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int bit_diff_clock      = 7;
	localparam int bit_first_pin_in    = 6;
	localparam int bit_compl_pin_in    = 5;
	localparam int bit_se_hold         = 4;
	localparam int bit_inv_sinc        = 3;
	localparam int bit_qmc_offset      = 2;
	localparam int bit_qmc_corr        = 1;
	localparam int bit_mixer           = 0;
	localparam int pos_diff_dly        = 6;
	localparam int pos_se_dly          = 4;
	localparam int bit_test_word_ena   = 7;
	localparam int pos_out_dly         = 5;
	localparam int bit_copy_a_to_b     = 4;
	localparam int bit_copy_b_to_a     = 3;
	localparam int bit_reverse_a       = 1;
	localparam int bit_reverse_b       = 0;
	localparam int sample_width        = 16;
	localparam int max_out_delay       = 3;
	// ****************************************
	// Timing of delay steps
	// ****************************************
	localparam real delay_step_ns = 1.0;
	localparam real clk_period_ns = 100.0;
	// Steps shorter than one cycle still cost at least one cycle
	localparam int delay_step_cycles = (delay_step_ns / clk_period_ns) > 1.0 ?
		int'(delay_step_ns / clk_period_ns) : 1;
	localparam int delay_chain_len = 3 * delay_step_cycles;
	// ****************************************
	// Types
	// ****************************************
	typedef logic [sample_width-1:0] sample_t;
	typedef struct packed {
		sample_t chan_one;
		sample_t chan_two;
	} sample_pair_t;
	typedef struct packed {
		logic diff_clock_sel;
		logic first_pin_input_enable;
		logic complement_pin_input_enable;
		logic single_ended_clock_hold;
		logic inverse_sinc_enable;
		logic qmc_offset_enable;
		logic qmc_corr_enable;
		logic mixer_enable;
	} stage_cfg_t;
	typedef struct packed {
		logic       out_en;
		logic       out_val;
	} pin_drive_t;
endpackage : clk_route_pkg

/* rtl/tap_delay.sv */
// Module: selectable clock delay line, 0 to 3 steps of one cycle each
`timescale 1ns/1ps
`default_nettype none
module tap_delay (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       enable_in,
	// Signal
	input  wire logic       sig_in,
	input  wire logic [1:0] sel_in,
	output logic            sig_out
);
	import clk_route_pkg::*;
	logic [delay_chain_len:0] chain;
	assign chain[0] = sig_in;
	genvar g;
	generate
		for (g = 1; g <= delay_chain_len; g++) begin : g_tap
			always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
				if (!reset_n_in)
					chain[g] <= 1'b0;
				else if (enable_in)
					chain[g] <= chain[g-1];
			end
		end
	endgenerate
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in)
			sig_out <= 1'b0;
		else if (enable_in)
			sig_out <= chain[int'(sel_in) * delay_step_cycles];
	end
endmodule // tap_delay
`default_nettype wire

/* tb/clk_route_props.sv */
// Checker: concurrent properties on the ports of the clock and route bank
`timescale 1ns/1ps
`default_nettype none
module clk_route_props (
	input wire logic                      clk_sys_in,
	input wire logic                      reset_n_in,
	input wire logic                      s_axi_awvalid_in,
	input wire logic                      s_axi_awready_out,
	input wire logic                      s_axi_wvalid_in,
	input wire logic                      s_axi_wready_out,
	input wire logic                      s_axi_bvalid_out,
	input wire logic                      s_axi_bready_in,
	input wire logic                      s_axi_arvalid_in,
	input wire logic                      s_axi_arready_out,
	input wire logic                      s_axi_rvalid_out,
	input wire logic                      s_axi_rready_in,
	input wire clk_route_pkg::stage_cfg_t stage_cfg_out,
	input wire clk_route_pkg::pin_drive_t shared_clock_pin_out,
	input wire clk_route_pkg::pin_drive_t complementary_clock_pin_out,
	input wire logic                      diff_clock_out,
	input wire logic                      single_ended_clock_out
);
	import clk_route_pkg::*;
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	// Both halves taken together: one edge pairs them, the next raises the answer
	a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read response late");
	a_bresp_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
		else $error("write response not retired");
	a_rresp_done: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
		else $error("read response not retired");
	// A second write must wait until the response has gone
	a_busy_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write accepted while busy");
	a_shared_dir: assert property ($stable(stage_cfg_out.first_pin_input_enable)
		|-> shared_clock_pin_out.out_en == !stage_cfg_out.first_pin_input_enable)
		else $error("shared pin direction wrong");
	a_compl_dir: assert property ($stable(stage_cfg_out.complement_pin_input_enable)
		|-> complementary_clock_pin_out.out_en == !stage_cfg_out.complement_pin_input_enable)
		else $error("complementary pin direction wrong");
	a_diff_off: assert property ((!stage_cfg_out.diff_clock_sel)[*6] |-> !diff_clock_out)
		else $error("differential clock runs while deselected");
	a_hold_one: assert property ((!stage_cfg_out.diff_clock_sel
		&& stage_cfg_out.single_ended_clock_hold)[*6] |-> single_ended_clock_out)
		else $error("single ended clock not held high");
	c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
	c_hold: cover property (stage_cfg_out.single_ended_clock_hold && single_ended_clock_out);
endmodule // clk_route_props
`default_nettype wire

/* tb/tb_dac_clock_and_route_config.sv */
// Testbench: register, routing, delay and clock pin checks of the clock and route bank
`timescale 1ns/1ps
`default_nettype none
module tb_dac_clock_and_route_config;
	import clk_route_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic         clk, rst_n, awv, wv, bready, arv, rready, prim, compl, shared, lock, dclk;
	logic         awr, wr, bv, arr, rv, dco, seo, ce;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, v;
	logic [1:0]   bresp, rresp;
	pin_drive_t   sho, cpo;
	stage_cfg_t   scfg;
	sample_pair_t psi, ssi, pso, cso, o, nw;
	int           fails, checked, cyc, seed, n, n0;
	clk_route_cfg dut (.clk_sys_in(clk), .reset_n_in(rst_n), .clk_en_in(ce),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .primary_clock_pin_in(prim),
		.complementary_clock_pin_in(compl), .shared_clock_pin_in(shared), .pll_lock_in(lock),
		.data_clock_in(dclk), .shared_clock_pin_out(sho), .complementary_clock_pin_out(cpo),
		.diff_clock_out(dco), .single_ended_clock_out(seo), .stage_cfg_out(scfg),
		.port_samples_in(psi), .stage_samples_in(ssi), .port_samples_out(pso),
		.converter_samples_out(cso));
	always #50 clk = ~clk;
	// Hang guard, generous against the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	// ****************************************
	// Tasks and expectation functions
	// ****************************************
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw;
		@(posedge clk) awaddr <= a;
		wdata <= d; awv <= 1; wv <= 1; bready <= 1;
		pa = 1; pw = 1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awr === 1) begin pa = 0; awv <= 0; end
			if (pw && wr === 1) begin pw = 0; wv <= 0; end
		end
		while (bv !== 1) @(posedge clk);
		bready <= 0;
		check(bresp, er);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk) araddr <= a;
		arv <= 1; rready <= 1;
		do @(posedge clk); while (arr !== 1);
		arv <= 0;
		do @(posedge clk); while (rv !== 1);
		rready <= 0;
		check(rdata, e);
		check(rresp, er);
	endtask
	// Cycles from a rising clock pin to the rising selected clock output
	task automatic meas(input bit se, output int cnt);
		@(posedge clk) prim <= 0;
		shared <= 0;
		repeat (10) @(posedge clk);
		if (se) shared <= 1;
		else prim <= 1;
		cnt = 0;
		do begin @(posedge clk); #1 cnt++; end while ((se ? seo : dco) !== 1 && cnt < 40);
	endtask
	function automatic sample_pair_t route(input logic [1:0] m, input sample_pair_t p);
		case (m)
			2'd0: return p;
			2'd1: return {p.chan_two, p.chan_two};
			2'd2: return {p.chan_one, p.chan_one};
			default: return {p.chan_two, p.chan_one};
		endcase
	endfunction
	function automatic sample_t rev(input sample_t x);
		return {<<{x}};
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'hc9fde8ff;
		clk = 0; rst_n = 0; fails = 0; checked = 0; cyc = 0;
		ce = 1;
		{awv, wv, bready, arv, rready, prim, compl, shared, lock, dclk} = '0;
		awaddr = 0; araddr = 0; wdata = 0; psi = 0; ssi = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(posedge clk); #1 check(scfg, rst_stage_enables);
		axr(addr_stage_enables, 32'(rst_stage_enables), resp_okay);
		axr(addr_tree_delay, 32'h0, resp_okay);
		axr(addr_routing, 32'h0, resp_okay);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			axw(addr_stage_enables, v, resp_okay);
			axr(addr_stage_enables, v & 32'hff, resp_okay);
			check(scfg, v & 32'hff);
			axw(addr_tree_delay, v, resp_okay);
			axr(addr_tree_delay, v & 32'hf0, resp_okay);
			axw(addr_routing, v, resp_okay);
			axr(addr_routing, v & 32'hfb, resp_okay);
		end
		axw(8'h40, v, resp_slverr);
		axr(8'h40, 32'h0, resp_slverr);
		$display("test registers done");
		for (int m = 0; m < 4; m++) for (int d = 0; d < 4; d++) begin
			axw(addr_routing, 32'(m * 8 + d * 32), resp_okay);
			o = $random(seed);
			nw = $random(seed);
			@(posedge clk) ssi <= o;
			repeat (6) @(posedge clk);
			ssi <= nw;
			repeat (d) @(posedge clk);
			#1 check(cso, route(2'(m), o));
			@(posedge clk);
			#1 check(cso, route(2'(m), nw));
		end
		v = $random(seed);
		axw(addr_test_word, v, resp_okay);
		axw(addr_routing, 32'h98, resp_okay);
		repeat (3) @(posedge clk);
		#1 check(cso, {v[15:0], v[15:0]});
		$display("test routing done");
		for (int f = 0; f < 4; f++) begin
			axw(addr_routing, 32'(f), resp_okay);
			o = $random(seed);
			@(posedge clk) psi <= o;
			repeat (2) @(posedge clk);
			nw = {f[1] ? rev(o.chan_one) : o.chan_one, f[0] ? rev(o.chan_two) : o.chan_two};
			#1 check(pso, nw);
			axr(addr_port_data, nw, resp_okay);
		end
		// Clock enable low must freeze the mirrored port register
		@(posedge clk) ce <= 0;
		psi <= ~o;
		repeat (3) @(posedge clk);
		#1 check(pso, nw);
		@(posedge clk) ce <= 1;
		$display("test reversal done");
		for (int k = 0; k < 2; k++) for (int s = 0; s < 4; s++) begin
			axw(addr_stage_enables, k ? 32'h60 : 32'he0, resp_okay);
			v = k ? 32'(s * 16 + (3 - s) * 64) : 32'(s * 64 + (3 - s) * 16);
			axw(addr_tree_delay, v, resp_okay);
			meas(k[0], n);
			if (s == 0) n0 = n;
			check(32'(n - n0), 32'(s));
		end
		$display("test clock delay done");
		axw(addr_stage_enables, 32'h70, resp_okay);
		@(posedge clk) prim <= 1;
		shared <= 0;
		repeat (8) @(posedge clk);
		#1 check(seo, 1);
		check(dco, 0);
		v = $random(seed);
		axw(addr_stage_enables, 32'h80, resp_okay);
		@(posedge clk) dclk <= v[0];
		lock <= v[1];
		repeat (6) @(posedge clk);
		#1 check(sho, {1'b1, v[0]});
		check(cpo, {1'b1, v[1]});
		axr(addr_status, {27'h0, 3'b100, v[1:0]}, resp_okay);
		axw(addr_stage_enables, 32'he1, resp_okay);
		repeat (3) @(posedge clk);
		#1 check(sho.out_en, 0);
		check(cpo.out_en, 0);
		$display("test clock pins done");
		stop_test();
	end
endmodule // tb_dac_clock_and_route_config
bind clk_route_cfg clk_route_props u_props (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.stage_cfg_out(stage_cfg_out), .shared_clock_pin_out(shared_clock_pin_out),
	.complementary_clock_pin_out(complementary_clock_pin_out),
	.diff_clock_out(diff_clock_out), .single_ended_clock_out(single_ended_clock_out));
`default_nettype wire
